// *** src/gpio_port.sv ***
// Behaviour
// RL1 - Twenty-four port bits in three byte groups, each direction set separately.
// RL2 - Writing zero to a direction bit selects input mode.
// RL3 - Input mode releases the driver; the pin floats.
// RL4 - Reading an input bit returns the live pin level.
// RL5 - Data writes in input mode are stored but leave the pin alone.
// RL6 - Writing one to a direction bit selects output mode.
// RL7 - Output mode drives the pin with the stored data bit.
// RL8 - Reading an output bit returns the stored data bit.
// RL9 - Reset clears all direction bits, so every bit starts as input.
// RL10 - Low nibbles of groups one and two may carry serial channels.
// RL11 - Serial output pins leave data and direction bits as plain storage.
// RL12 - Serial input pins leave direction bits as plain storage.
// RL13 - Groups one and two select Schmitt on one, CMOS on zero; reset CMOS.
// RL14 - Pull-up bit one enables pull-up in input mode; zero disables it.
// RL15 - Output mode always disables the pull-up.
// RL16 - Reset sets every pull-up bit to one.
// RL17 - Software sets direction to output before using a special output.
// RL18 - Timer clock enable overrides the pin; clear returns normal output.
// RL19 - Timers zero and one feed special pin zero, two and three pin one.
// RL20 - With both enabled, timer one wins on special pin zero.
// RL21 - With both enabled, timer three wins on special pin one.
// RL22 - Switching a timer clock output glitches at most half a period.
// RL23 - Oscillator enable overrides special pin two with the divided clock.
// RL24 - Three-bit select picks low or high oscillator over 1, 2, 4, 8.
// RL25 - Switching the divided clock output glitches at most half a cycle.
// RL26 - Inverted timer two or three drives special pin three; three wins.
// RL27 - Switching the inverted output glitches at most half a cycle.
// RL28 - Reset sets every data bit to one.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

`include "gpio_port_map.svh"

module gpio_port #(
  parameter int GROUPS = 3
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic [7:0]              i_addr,
  input  wire logic [7:0]              i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [7:0]              o_rdata,
  input  wire logic [GROUPS*8-1:0]     i_pin,
  output logic      [GROUPS*8-1:0]     o_pin_out,
  output logic      [GROUPS*8-1:0]     o_pin_oe,
  output logic      [GROUPS*8-1:0]     o_pullup_en,
  output logic      [15:0]             o_schmitt_sel,
  input  wire logic [7:0]              i_serial_out_sel,
  input  wire logic [7:0]              i_serial_in_sel,
  input  wire logic [7:0]              i_serial_out,
  output logic      [7:0]              o_serial_in,
  input  wire logic [3:0]              i_timer_clk,
  input  wire logic                    i_low_osc_clk,
  input  wire logic                    i_high_osc_clk
);

  localparam int NBITS = GROUPS * 8;

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [NBITS-1:0] port_direction_bit;
  logic [NBITS-1:0] port_data_bit;
  logic [NBITS-1:0] port_pullup_enable_bit;
  logic [15:0]      port_schmitt_select_bit;
  logic [3:0]       timer_clock_pin_enable;
  logic [1:0]       inverted_timer_pin_enable;
  logic             osc_divider_pin_enable;
  gpio_port_pkg::osc_sel_t osc_divider_freq_select;

  logic             divided_oscillator_signal;

  ////////////////////////////////////////////////////////////////////////
  // Direction bits

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port_direction_bit <= {GROUPS{`RST_DIR}}; // RL9
    end else if (i_wr) begin
      case (i_addr)
        `REG_DIR_G0: port_direction_bit[7:0]   <= i_wdata; // RL2 RL6
        `REG_DIR_G1: port_direction_bit[15:8]  <= i_wdata; // RL2 RL6
        `REG_DIR_G2: port_direction_bit[23:16] <= i_wdata; // RL2 RL6
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data bits, stored whatever the pin mode

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port_data_bit <= {GROUPS{`RST_DATA}}; // RL28
    end else if (i_wr) begin
      case (i_addr)
        `REG_DATA_G0: port_data_bit[7:0]   <= i_wdata; // RL5
        `REG_DATA_G1: port_data_bit[15:8]  <= i_wdata; // RL5
        `REG_DATA_G2: port_data_bit[23:16] <= i_wdata; // RL5
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pull-up bits

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port_pullup_enable_bit <= {GROUPS{`RST_PULL}}; // RL16
    end else if (i_wr) begin
      case (i_addr)
        `REG_PULL_G0: port_pullup_enable_bit[7:0]   <= i_wdata;
        `REG_PULL_G1: port_pullup_enable_bit[15:8]  <= i_wdata;
        `REG_PULL_G2: port_pullup_enable_bit[23:16] <= i_wdata;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input level select, groups one and two only

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port_schmitt_select_bit <= {2{`RST_SCHMITT}}; // RL13
    end else if (i_wr) begin
      case (i_addr)
        `REG_SCHMITT_G1: port_schmitt_select_bit[7:0]  <= i_wdata; // RL13
        `REG_SCHMITT_G2: port_schmitt_select_bit[15:8] <= i_wdata; // RL13
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Special output controls

  // Both enable fields share one byte; each keeps its own flip-flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_clock_pin_enable <= 4'(`RST_TIMER_PIN);
    end else if (i_wr && i_addr == `REG_TIMER_PIN) begin
      timer_clock_pin_enable <=
        i_wdata[`TPIN_TIMER_MSB:`TPIN_TIMER_LSB]; // RL18
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      inverted_timer_pin_enable <= 2'(`RST_TIMER_PIN >> `TPIN_INV_LSB);
    end else if (i_wr && i_addr == `REG_TIMER_PIN) begin
      inverted_timer_pin_enable <=
        i_wdata[`TPIN_INV_MSB:`TPIN_INV_LSB]; // RL26
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_divider_pin_enable  <= `RST_OSC_EN;
      osc_divider_freq_select <= gpio_port_pkg::osc_sel_t'(`RST_OSC_SEL);
    end else if (i_wr && i_addr == `REG_OSC_PIN) begin
      osc_divider_pin_enable  <= i_wdata[`OPIN_EN_BIT];
      osc_divider_freq_select <= gpio_port_pkg::osc_sel_t'(
        i_wdata[`OPIN_SEL_MSB:`OPIN_SEL_LSB]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divided oscillator clock

  osc_divider u_osc_divider (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_low_osc_clk  (i_low_osc_clk),
    .i_high_osc_clk (i_high_osc_clk),
    .i_sel          (osc_divider_freq_select),
    .o_div_clk      (divided_oscillator_signal)
  );

  ////////////////////////////////////////////////////////////////////////
  // Special pin sources; the later timer of each pair takes priority

  logic special0_clk;
  logic special1_clk;
  logic special3_clk;

  always_comb begin
    special0_clk = timer_clock_pin_enable[1] ? i_timer_clk[1] // RL20
                                             : i_timer_clk[0]; // RL19
    special1_clk = timer_clock_pin_enable[3] ? i_timer_clk[3] // RL21
                                             : i_timer_clk[2]; // RL19
    special3_clk = inverted_timer_pin_enable[1] ? !i_timer_clk[3]
                                                : !i_timer_clk[2]; // RL26
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-pin output selection

  logic [NBITS-1:0] special_on;
  logic [NBITS-1:0] special_val;
  logic [NBITS-1:0] ser_out_on;
  logic [NBITS-1:0] ser_in_on;
  logic [NBITS-1:0] ser_val;
  logic [NBITS-1:0] next_pin_out;
  logic [NBITS-1:0] next_pin_oe;

  always_comb begin
    special_on  = '0;
    special_val = '0;
    ser_out_on  = '0;
    ser_in_on   = '0;
    ser_val     = '0;
    special_on[`PIN_SPECIAL0]  = |timer_clock_pin_enable[1:0]; // RL18
    special_val[`PIN_SPECIAL0] = special0_clk;
    special_on[`PIN_SPECIAL1]  = |timer_clock_pin_enable[3:2]; // RL18
    special_val[`PIN_SPECIAL1] = special1_clk;
    special_on[`PIN_SPECIAL2]  = osc_divider_pin_enable; // RL23
    special_val[`PIN_SPECIAL2] = divided_oscillator_signal;
    special_on[`PIN_SPECIAL3]  = |inverted_timer_pin_enable; // RL26
    special_val[`PIN_SPECIAL3] = special3_clk;
    ser_out_on[`PIN_SERIAL0_LSB +: 4] = i_serial_out_sel[3:0]; // RL10
    ser_out_on[`PIN_SERIAL1_LSB +: 4] = i_serial_out_sel[7:4]; // RL10
    ser_in_on[`PIN_SERIAL0_LSB +: 4]  = i_serial_in_sel[3:0];
    ser_in_on[`PIN_SERIAL1_LSB +: 4]  = i_serial_in_sel[7:4];
    ser_val[`PIN_SERIAL0_LSB +: 4]    = i_serial_out[3:0];
    ser_val[`PIN_SERIAL1_LSB +: 4]    = i_serial_out[7:4];
  end

  // Software is expected to set the direction bit before enabling a
  // special output; the override itself drives the pin regardless.
  genvar g;
  generate
    for (g = 0; g < NBITS; g++) begin : g_pin
      always_comb begin
        if (special_on[g]) begin
          next_pin_out[g] = special_val[g]; // RL18 RL17
          next_pin_oe[g]  = 1'h1;
        end else if (ser_out_on[g]) begin
          next_pin_out[g] = ser_val[g]; // RL11
          next_pin_oe[g]  = 1'h1;
        end else if (ser_in_on[g]) begin
          next_pin_out[g] = 1'h0; // RL12
          next_pin_oe[g]  = 1'h0;
        end else begin
          next_pin_out[g] = port_data_bit[g]; // RL7
          next_pin_oe[g]  = port_direction_bit[g]; // RL1 RL3
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin outputs

  // Enables and clocks are both sampled on i_clk, so switching a special
  // output on or off can cut a clock level short to a single i_clk cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out <= '0;
    end else begin
      o_pin_out <= next_pin_out; // RL22 RL25 RL27
    end
  end

  // The enable moves in the same cycle as the value, so a pin never
  // drives a stale level for a cycle when an override switches.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_oe <= '0;
    end else begin
      o_pin_oe <= next_pin_oe; // RL3
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pullup_en <= '0;
    end else begin
      o_pullup_en <= port_pullup_enable_bit & ~next_pin_oe; // RL14 RL15
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_schmitt_sel <= '0;
    end else begin
      o_schmitt_sel <= port_schmitt_select_bit; // RL13
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_in <= '0;
    end else begin
      o_serial_in <= {i_pin[`PIN_SERIAL1_LSB +: 4],
                      i_pin[`PIN_SERIAL0_LSB +: 4]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read

  // Port reads follow the plain direction bit, not overrides.
  logic [NBITS-1:0] port_view;

  assign port_view = (port_direction_bit & port_data_bit) // RL8
                   | (~port_direction_bit & i_pin); // RL4

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `REG_DIR_G0:     o_rdata <= port_direction_bit[7:0];
        `REG_DIR_G1:     o_rdata <= port_direction_bit[15:8];
        `REG_DIR_G2:     o_rdata <= port_direction_bit[23:16];
        `REG_DATA_G0:    o_rdata <= port_view[7:0];
        `REG_DATA_G1:    o_rdata <= port_view[15:8];
        `REG_DATA_G2:    o_rdata <= port_view[23:16];
        `REG_PULL_G0:    o_rdata <= port_pullup_enable_bit[7:0];
        `REG_PULL_G1:    o_rdata <= port_pullup_enable_bit[15:8];
        `REG_PULL_G2:    o_rdata <= port_pullup_enable_bit[23:16];
        `REG_SCHMITT_G1: o_rdata <= port_schmitt_select_bit[7:0];
        `REG_SCHMITT_G2: o_rdata <= port_schmitt_select_bit[15:8];
        `REG_TIMER_PIN:  o_rdata <= {2'h0, inverted_timer_pin_enable,
                                     timer_clock_pin_enable};
        `REG_OSC_PIN:    o_rdata <= {1'h0, osc_divider_freq_select,
                                     osc_divider_pin_enable, 3'h0};
        default:         o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // gpio_port

`default_nettype wire

// *** pkg/gpio_port_map.svh ***
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

// Register byte offsets on the 8-bit register port
`define REG_DIR_G0        8'h60
`define REG_DIR_G1        8'h61
`define REG_DATA_G0       8'h62
`define REG_DATA_G1       8'h63
`define REG_PULL_G0       8'h64
`define REG_PULL_G1       8'h65
`define REG_SCHMITT_G1    8'h67
`define REG_DIR_G2        8'h68
`define REG_DATA_G2       8'h6A
`define REG_PULL_G2       8'h6C
`define REG_SCHMITT_G2    8'h6E
`define REG_TIMER_PIN     8'h70
`define REG_OSC_PIN       8'h71

// Reset values
`define RST_DIR           8'h00
`define RST_DATA          8'hFF
`define RST_PULL          8'hFF
`define RST_SCHMITT       8'h00
`define RST_TIMER_PIN     6'h00
`define RST_OSC_EN        1'h0
`define RST_OSC_SEL       3'h0

// Field positions in the timer pin register
`define TPIN_TIMER_LSB    0
`define TPIN_TIMER_MSB    3
`define TPIN_INV_LSB      4
`define TPIN_INV_MSB      5

// Field positions in the oscillator pin register
`define OPIN_EN_BIT       3
`define OPIN_SEL_LSB      4
`define OPIN_SEL_MSB      6

// Pin indices of the special outputs and the serial nibbles
`define PIN_SPECIAL0      12
`define PIN_SPECIAL1      13
`define PIN_SPECIAL2      14
`define PIN_SPECIAL3      15
`define PIN_SERIAL0_LSB   8
`define PIN_SERIAL1_LSB   16

`endif

// *** pkg/gpio_port_pkg.sv ***
package gpio_port_pkg;

  typedef logic [7:0] port_byte_t;

  // Divided oscillator select codes
  typedef enum logic [2:0] {
    LOW_DIV1  = 3'h0,
    LOW_DIV2  = 3'h1,
    LOW_DIV4  = 3'h2,
    LOW_DIV8  = 3'h3,
    HIGH_DIV1 = 3'h4,
    HIGH_DIV2 = 3'h5,
    HIGH_DIV4 = 3'h6,
    HIGH_DIV8 = 3'h7
  } osc_sel_t;

endpackage

// *** src/osc_divider.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "gpio_port_map.svh"

module osc_divider (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_low_osc_clk,
  input  wire logic                  i_high_osc_clk,
  input  wire gpio_port_pkg::osc_sel_t i_sel,
  output logic                       o_div_clk
);

  logic       low_prev;
  logic       high_prev;
  logic [2:0] low_cnt;
  logic [2:0] high_cnt;
  logic       src;
  logic [2:0] cnt;
  logic       next_div;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_prev  <= 1'h0;
      high_prev <= 1'h0;
      low_cnt   <= 3'h0;
      high_cnt  <= 3'h0;
    end else begin
      low_prev  <= i_low_osc_clk;
      high_prev <= i_high_osc_clk;
      if (i_low_osc_clk && !low_prev) begin
        low_cnt <= low_cnt + 3'h1;
      end
      if (i_high_osc_clk && !high_prev) begin
        high_cnt <= high_cnt + 3'h1;
      end
    end
  end

  // Bit n of a rising-edge counter runs at the source rate over 2^(n+1)
  always_comb begin
    src = i_sel[2] ? i_high_osc_clk : i_low_osc_clk;
    cnt = i_sel[2] ? high_cnt : low_cnt;
    case (i_sel[1:0])
      2'h0:    next_div = src;
      2'h1:    next_div = cnt[0];
      2'h2:    next_div = cnt[1];
      2'h3:    next_div = cnt[2];
      default: next_div = src;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_div_clk <= 1'h0;
    end else begin
      o_div_clk <= next_div; // RL24
    end
  end

endmodule // osc_divider

`default_nettype wire

// *** bench/gpio_port_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_map.svh"
module gpio_port_checker #(
  parameter int GROUPS = 3
) (
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  input wire logic [7:0]            i_addr,
  input wire logic [7:0]            i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [7:0]            o_rdata,
  input wire logic [GROUPS*8-1:0]   i_pin,
  input wire logic [GROUPS*8-1:0]   o_pin_out,
  input wire logic [GROUPS*8-1:0]   o_pin_oe,
  input wire logic [GROUPS*8-1:0]   o_pullup_en,
  input wire logic [15:0]           o_schmitt_sel,
  input wire logic [7:0]            i_serial_out_sel,
  input wire logic [7:0]            i_serial_in_sel,
  input wire logic [7:0]            i_serial_out,
  input wire logic [3:0]            i_timer_clk
);
  logic [7:0] dir0;
  logic [7:0] dat0;
  logic [5:0] tp;
  logic [7:0] rd_exp;
  logic [7:0] so_pin;
  logic [7:0] so_oe;
  logic       e12;
  logic       e13;
  logic       e15;
  ////////////////////////////////////////
  // Mirrors only what the properties need
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dir0 <= `RST_DIR;
      dat0 <= `RST_DATA;
      tp <= `RST_TIMER_PIN;
    end else if (i_wr) begin
      case (i_addr)
        `REG_DIR_G0: dir0 <= i_wdata;
        `REG_DATA_G0: dat0 <= i_wdata;
        `REG_TIMER_PIN: tp <= i_wdata[5:0];
        default: ;
      endcase
    end
  end
  assign rd_exp = (dir0 & dat0) | (~dir0 & i_pin[7:0]);
  assign e12 = tp[1] ? i_timer_clk[1] : i_timer_clk[0];
  assign e13 = tp[3] ? i_timer_clk[3] : i_timer_clk[2];
  assign e15 = tp[5] ? ~i_timer_clk[3] : ~i_timer_clk[2];
  assign so_pin = {o_pin_out[19:16], o_pin_out[11:8]};
  assign so_oe = {o_pin_oe[19:16], o_pin_oe[11:8]};
  ////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_pull_not_driving: assert property ((o_pullup_en & o_pin_oe) == '0)
    else $error("pull-up on a driven pin");
  a_reset_state: assert property ($fell(i_rst) |=>
    o_pin_oe == '0 && &o_pullup_en && o_schmitt_sel == 16'h0000)
    else $error("wrong pin state after reset");
  a_group0_dir: assert property (o_pin_oe[7:0] == $past(dir0))
    else $error("drive enable does not follow direction");
  a_group0_data: assert property (
    ((o_pin_out[7:0] ^ $past(dat0)) & $past(dir0)) == 8'h00)
    else $error("output pin differs from data");
  a_read_view: assert property (
    $past(i_rd) && $past(i_addr) == `REG_DATA_G0 |-> o_rdata == $past(rd_exp))
    else $error("data read mixes pins and data wrongly");
  a_timer_pin0: assert property ($past(tp[0]) || $past(tp[1]) |->
    o_pin_oe[12] && o_pin_out[12] == $past(e12))
    else $error("timer clock missing on first special pin");
  a_timer_pin1: assert property ($past(tp[2]) || $past(tp[3]) |->
    o_pin_oe[13] && o_pin_out[13] == $past(e13))
    else $error("timer clock missing on second special pin");
  a_inverted_pin: assert property ($past(tp[4]) || $past(tp[5]) |->
    o_pin_oe[15] && o_pin_out[15] == $past(e15))
    else $error("inverted timer clock missing");
  a_serial_out: assert property (
    ((~so_oe | (so_pin ^ $past(i_serial_out))) & $past(i_serial_out_sel))
    == 8'h00)
    else $error("serial output not on its pin");
  a_serial_in: assert property (
    (so_oe & $past(i_serial_in_sel) & ~$past(i_serial_out_sel)) == 8'h00)
    else $error("serial input pin is driven");
  c_timer_both: cover property (tp[1:0] == 2'h3);
  c_serial: cover property (i_serial_out_sel != 8'h00);
  c_read: cover property (i_rd && i_addr == `REG_DATA_G0);
endmodule // gpio_port_checker

bind gpio_port gpio_port_checker #(.GROUPS(GROUPS)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en),
  .o_schmitt_sel(o_schmitt_sel), .i_serial_out_sel(i_serial_out_sel),
  .i_serial_in_sel(i_serial_in_sel), .i_serial_out(i_serial_out),
  .i_timer_clk(i_timer_clk)
);
`default_nettype wire

// *** bench/board_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module board_model (
  input  wire logic        i_clk,
  input  wire logic [23:0] i_out,
  input  wire logic [23:0] i_oe,
  input  wire logic [23:0] i_pull,
  input  wire logic [23:0] i_ext_en,
  input  wire logic [23:0] i_ext_val,
  output logic      [23:0] o_pin
);
  // Floating pins wander so a stale level never passes as valid
  logic [23:0] drift = 24'hAAAAAA;
  always @(posedge i_clk) drift <= ~drift;
  // Device drive wins over the board, the board over the pull resistor
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
               | (~i_oe & ~i_ext_en & (i_pull | drift));
endmodule // board_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        i_clk, i_rst, i_wr, i_rd, i_low_osc_clk, i_high_osc_clk;
  logic [7:0]  i_addr, i_wdata, o_rdata, o_serial_in, cnt;
  logic [7:0]  i_serial_out_sel, i_serial_in_sel, i_serial_out;
  logic [23:0] i_pin, o_pin_out, o_pin_oe, o_pullup_en, ext_en, ext_val;
  logic [15:0] o_schmitt_sel;
  logic [3:0]  i_timer_clk;
  int          err_count, checked;
  gpio_port #(.GROUPS(3)) dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_pin, .o_pin_out, .o_pin_oe, .o_pullup_en,
    .o_schmitt_sel, .i_serial_out_sel, .i_serial_in_sel, .i_serial_out,
    .o_serial_in, .i_timer_clk, .i_low_osc_clk, .i_high_osc_clk);
  board_model u_board (.i_clk, .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_pull(o_pullup_en), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pin(i_pin));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // Sources stay far below half the system clock
  always @(posedge i_clk) begin
    cnt <= i_rst ? 8'h00 : cnt + 8'h01;
    i_timer_clk <= cnt[5:2];
    i_high_osc_clk <= cnt[1];
    i_low_osc_clk <= cnt[3];
  end
  ////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(24'(o_rdata), 24'(e));
  endtask
  task automatic settle;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] a [15];
    logic [7:0] v [15];
    a = '{8'h60, 8'h61, 8'h68, 8'h64, 8'h65, 8'h6C, 8'h67, 8'h6E,
          8'h70, 8'h71, 8'h66, 8'h7F, 8'h62, 8'h63, 8'h6A};
    v = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00,
          8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
    wr(8'h7F, 8'hFF);
    settle();
    chk(o_pin_oe, 24'h000000);
    chk(o_pullup_en, 24'hFFFFFF);
    chk(24'(o_schmitt_sel), 24'h000000);
    for (int k = 0; k < 15; k++) rchk(a[k], v[k]);
  endtask
  task automatic t_input;
    @(posedge i_clk);
    ext_en <= 24'h0000FF;
    ext_val <= 24'h00005A;
    wr(8'h62, 8'h00);
    settle();
    chk(24'(o_pin_oe[7:0]), 24'h000000);
    rchk(8'h62, 8'h5A);
    wr(8'h64, 8'h0F);
    settle();
    chk(24'(o_pullup_en[7:0]), 24'h00000F);
    wr(8'h64, 8'hFF);
    wr(8'h60, 8'hF0);
    settle();
    chk(24'(o_pin_oe[7:0]), 24'h0000F0);
    chk(24'(o_pin_out[7:4]), 24'h000000);
    chk(24'(o_pullup_en[7:0]), 24'h00000F);
    rchk(8'h62, 8'h0A);
    @(posedge i_clk);
    ext_en <= 24'h000000;
  endtask
  task automatic t_output;
    wr(8'h68, 8'hFF);
    settle();
    chk(24'(o_pin_out[23:16]), 24'h0000FF);
    rchk(8'h6A, 8'hFF);
    wr(8'h6A, 8'h3C);
    settle();
    chk(24'(o_pin_out[23:16]), 24'h00003C);
    chk(24'(o_pin_oe[23:16]), 24'h0000FF);
    wr(8'h68, 8'h00);
    settle();
    chk(24'(o_pin_oe[23:16]), 24'h000000);
  endtask
  task automatic t_schmitt;
    wr(8'h67, 8'hA5);
    wr(8'h6E, 8'h5A);
    settle();
    chk(24'(o_schmitt_sel), 24'h005AA5);
    rchk(8'h67, 8'hA5);
    rchk(8'h6E, 8'h5A);
  endtask
  task automatic t_serial;
    wr(8'h61, 8'h00);
    wr(8'h68, 8'hFF);
    @(posedge i_clk);
    i_serial_out_sel <= 8'h03;
    i_serial_in_sel <= 8'h30;
    i_serial_out <= 8'h01;
    ext_en <= 24'h030000;
    ext_val <= 24'h020000;
    settle();
    chk(24'(o_pin_out[9:8]), 24'h000001);
    chk(24'(o_pin_oe[9:8]), 24'h000003);
    chk(24'(o_pin_oe[17:16]), 24'h000000);
    chk(24'(o_serial_in[5:4]), 24'h000002);
    rchk(8'h68, 8'hFF);
    @(posedge i_clk);
    i_serial_out_sel <= 8'h00;
    i_serial_in_sel <= 8'h00;
    ext_en <= 24'h000000;
    settle();
    chk(24'(o_pin_oe[17:16]), 24'h000003);
  endtask
  task automatic t_special;
    logic [7:0] c [6];
    int         p [6];
    int         s [6];
    logic [3:0] t;
    c = '{8'h01, 8'h03, 8'h04, 8'h0C, 8'h10, 8'h30};
    p = '{12, 12, 13, 13, 15, 15};
    s = '{0, 1, 2, 3, 2, 3};
    wr(8'h61, 8'hF0);
    wr(8'h63, 8'h00);
    for (int k = 0; k < 6; k++) begin
      wr(8'h70, c[k]);
      settle();
      chk(24'(o_pin_oe[p[k]]), 24'h000001);
      repeat (8) begin
        @(posedge i_clk);
        t = i_timer_clk;
        #1;
        chk(24'(o_pin_out[p[k]]), 24'(t[s[k]] ^ (k > 3)));
      end
    end
    wr(8'h70, 8'h00);
    settle();
    chk(24'(o_pin_out[15:12]), 24'h000000);
  endtask
  task automatic t_osc;
    int   n;
    int   e;
    logic prev;
    for (int s = 0; s < 8; s++) begin
      wr(8'h71, 8'(8'h08 | (s << 4)));
      repeat (40) @(posedge i_clk);
      chk(24'(o_pin_oe[14]), 24'h000001);
      n = 0;
      prev = 1'b1;
      repeat (512) begin
        @(posedge i_clk);
        #1;
        if (o_pin_out[14] === 1'b1 && prev === 1'b0) n++;
        prev = o_pin_out[14];
      end
      e = (s < 4) ? (32 >> s) : (128 >> (s - 4));
      chk(24'(n >= e - 1 && n <= e + 1), 24'h000001);
    end
    wr(8'h71, 8'h00);
    settle();
    chk(24'(o_pin_out[14]), 24'h000000);
  endtask
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {3'h4, 16'h0000};
    {i_serial_out_sel, i_serial_in_sel, i_serial_out} = 24'h000000;
    {ext_en, ext_val, err_count, checked} = '0;
    do_reset();
    t_reset();
    t_input();
    t_output();
    t_schmitt();
    t_serial();
    t_special();
    t_osc();
    do_reset();
    t_reset();
    tally_and_finish();
  end
  // Whole run needs about 4700 cycles
  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
